// ===== hw/cmd_link_regs.vh
`ifndef CMD_LINK_REGS_VH
`define CMD_LINK_REGS_VH
// Frame marker defaults, values arbitrary
`define FRM_START      8'h7e
`define FRM_STOP       8'h7d
`define FRM_ESC        8'h7c
// Command codes
`define CMD_INVALID    8'h00
`define CMD_TEST       8'h04
`define CMD_LOG        8'h06
`define CMD_SW_RESET   8'h08
`define CMD_ACK        8'h0a
`define CMD_NAK        8'h0b
`define CMD_SW_VERSION 8'h0c
// Buffer and frame limits
`define FIFO_DEPTH     16
`define MAX_PAYLOAD    16
`endif

// ===== hw/frame_fifo.v
`timescale 1ns/100ps
`default_nettype none
module frame_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0]    wr_r;
    reg [AW-1:0]    rd_r;
    reg [AW:0]      cnt_r;
    wire            push = in_valid && in_ready;
    wire            pop  = out_valid && out_ready;

    assign in_ready  = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data  = mem_r[rd_r];

    always @(posedge clk)
    begin
        if (push)
            mem_r[wr_r] <= in_data;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_r  <= {AW{1'b0}};
            rd_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
            if (pop)
                rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
            if (push && !pop)
                cnt_r <= cnt_r + 1'b1;
            else if (pop && !push)
                cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== hw/serial_command_link.v
// What this block does
// - One master, one slave; separate receive and transmit byte streams.
// - Slave starts frames on its own; no interrupt or ready line.
// - Start, stop and escape are the three reserved byte values.
// - Reserved payload bytes go inverted after escape; receiver re-inverts.
// - Software reset command answered with acknowledge frame, code 0x0A.
// - Failed command answered with not-acknowledge frame, code 0x0B.
// - Slave may push unsolicited log frames, code 0x06.
// - Test frame 0x04 echoed back unchanged, payload included.
// - Code 0x08 triggers a software reset pulse.
// - Code 0x0C answered with the software version.
`timescale 1ns/100ps
`default_nettype none
`include "cmd_link_regs.vh"
module serial_command_link #(
    parameter [7:0] SW_VERSION = 8'h01,
    parameter       PAYLOAD_AW = 4
) (
    input  wire       clk,
    input  wire       resetn,
    input  wire [7:0] rx_byte,
    input  wire       rx_valid,
    output reg  [7:0] tx_byte_r,
    output reg        tx_valid_r,
    input  wire       tx_ready,
    input  wire [7:0] log_byte,
    input  wire       log_valid,
    output reg        log_ready_r,
    input  wire       log_last,
    output reg        sw_reset_r,
    output reg        busy_r
);
    // ****************************************************************
    // Reset and input synchronisers
    // ****************************************************************
    reg       rst_s1_r;
    reg       rst_n_r;
    reg [7:0] rxb_s1_r;
    reg [7:0] rxb_r;
    reg [1:0] rxv_s_r;
    reg       rxv_d_r;
    reg       txr_s1_r;
    reg       txr_r;
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    always @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            rxb_s1_r <= 8'h00;
            rxb_r    <= 8'h00;
            rxv_s_r  <= 2'b00;
            rxv_d_r  <= 1'b0;
            txr_s1_r <= 1'b0;
            txr_r    <= 1'b0;
        end
        else
        begin
            rxb_s1_r <= rx_byte;
            rxb_r    <= rxb_s1_r;
            rxv_s_r  <= {rxv_s_r[0], rx_valid};
            rxv_d_r  <= rxv_s_r[1];
            txr_s1_r <= tx_ready;
            txr_r    <= txr_s1_r;
        end
    end
    wire rx_stb = rxv_s_r[1] && !rxv_d_r;

    function is_marker;
        input [7:0] b;
        begin
            is_marker = (b == `FRM_START) || (b == `FRM_STOP) || (b == `FRM_ESC);
        end
    endfunction

    // ****************************************************************
    // Receive deframer
    // ****************************************************************
    reg                  in_frame_r;
    reg                  esc_r;
    reg                  have_cmd_r;
    reg [7:0]            cmd_r;
    reg [PAYLOAD_AW:0]   plen_r;
    reg                  ovf_r;
    reg [7:0]            pay_r [0:`MAX_PAYLOAD-1];
    reg                  frame_done_r;
    wire [7:0]           rx_data = esc_r ? ~rxb_r : rxb_r;
    always @(posedge clk)
    begin
        if (rx_stb && in_frame_r && !is_marker(rxb_r) && have_cmd_r && !plen_r[PAYLOAD_AW])
            pay_r[plen_r[PAYLOAD_AW-1:0]] <= rx_data;
    end
    always @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            in_frame_r   <= 1'b0;
            esc_r        <= 1'b0;
            have_cmd_r   <= 1'b0;
            cmd_r        <= 8'h00;
            plen_r       <= {(PAYLOAD_AW+1){1'b0}};
            ovf_r        <= 1'b0;
            frame_done_r <= 1'b0;
        end
        else
        begin
            frame_done_r <= 1'b0;
            if (rx_stb)
            begin
                if (rxb_r == `FRM_START)
                begin
                    in_frame_r <= 1'b1;
                    esc_r      <= 1'b0;
                    have_cmd_r <= 1'b0;
                    plen_r     <= {(PAYLOAD_AW+1){1'b0}};
                    ovf_r      <= 1'b0;
                end
                else if (in_frame_r && rxb_r == `FRM_STOP)
                begin
                    in_frame_r   <= 1'b0;
                    frame_done_r <= have_cmd_r && !busy_r;
                end
                else if (in_frame_r && rxb_r == `FRM_ESC)
                    esc_r <= 1'b1;
                else if (in_frame_r)
                begin
                    esc_r <= 1'b0;
                    if (!have_cmd_r)
                    begin
                        cmd_r      <= rx_data;
                        have_cmd_r <= 1'b1;
                    end
                    else if (plen_r[PAYLOAD_AW])
                        ovf_r <= 1'b1;
                    else
                        plen_r <= plen_r + 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // Reply builder and stuffer into FIFO
    // ****************************************************************
    localparam [5:0] S_IDLE  = 6'b000001;
    localparam [5:0] S_START = 6'b000010;
    localparam [5:0] S_CODE  = 6'b000100;
    localparam [5:0] S_BODY  = 6'b001000;
    localparam [5:0] S_STOP  = 6'b010000;
    localparam [5:0] S_LOG   = 6'b100000;
    reg [5:0]          st_r;
    reg [7:0]          rcode_r;
    reg [PAYLOAD_AW:0] rlen_r;
    reg [PAYLOAD_AW:0] ridx_r;
    reg                resc_r;
    reg                echo_r;
    reg                log_last_r;
    reg [8:0]          f_in;
    reg                f_valid;
    wire               f_ready;
    wire [8:0]         f_out;
    wire               f_out_valid;
    wire [7:0]         body = echo_r ? pay_r[ridx_r[PAYLOAD_AW-1:0]] : SW_VERSION;
    wire [7:0]         raw  = (st_r == S_CODE) ? rcode_r : (st_r == S_LOG ? log_byte : body);
    wire               need_esc = is_marker(raw) && !resc_r;

    always @*
    begin
        f_valid = 1'b0;
        f_in    = {1'b0, raw};
        case (st_r)
            S_START:
            begin
                f_valid = 1'b1;
                f_in    = {1'b1, `FRM_START};
            end
            S_STOP:
            begin
                f_valid = 1'b1;
                f_in    = {1'b1, `FRM_STOP};
            end
            S_CODE, S_BODY:
            begin
                f_valid = 1'b1;
                f_in    = need_esc ? {1'b0, `FRM_ESC} : {1'b0, resc_r ? ~raw : raw};
            end
            S_LOG:
            begin
                f_valid = log_valid || log_last_r;
                f_in    = log_last_r ? {1'b1, `FRM_STOP} :
                          (need_esc ? {1'b0, `FRM_ESC} : {1'b0, resc_r ? ~raw : raw});
            end
            default:
            begin
                f_valid = 1'b0;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            st_r        <= S_IDLE;
            rcode_r     <= 8'h00;
            rlen_r      <= {(PAYLOAD_AW+1){1'b0}};
            ridx_r      <= {(PAYLOAD_AW+1){1'b0}};
            resc_r      <= 1'b0;
            echo_r      <= 1'b0;
            log_last_r  <= 1'b0;
            sw_reset_r  <= 1'b0;
            busy_r      <= 1'b0;
            log_ready_r <= 1'b0;
        end
        else
        begin
            sw_reset_r  <= 1'b0;
            log_ready_r <= 1'b0;
            case (st_r)
                S_IDLE:
                begin
                    ridx_r <= {(PAYLOAD_AW+1){1'b0}};
                    echo_r <= 1'b0;
                    rlen_r <= {(PAYLOAD_AW+1){1'b0}};
                    if (frame_done_r)
                    begin
                        busy_r <= 1'b1;
                        st_r   <= S_START;
                        if (ovf_r)
                            rcode_r <= `CMD_NAK;
                        else if (cmd_r == `CMD_TEST)
                        begin
                            rcode_r <= `CMD_TEST;
                            echo_r  <= 1'b1;
                            rlen_r  <= plen_r;
                        end
                        else if (cmd_r == `CMD_SW_VERSION)
                        begin
                            rcode_r <= `CMD_SW_VERSION;
                            rlen_r  <= {{PAYLOAD_AW{1'b0}}, 1'b1};
                        end
                        else if (cmd_r == `CMD_SW_RESET)
                        begin
                            rcode_r    <= `CMD_ACK;
                            sw_reset_r <= 1'b1;
                        end
                        else
                            rcode_r <= `CMD_NAK;
                    end
                    else if (log_valid)
                    begin
                        busy_r  <= 1'b1;
                        rcode_r <= `CMD_LOG;
                        st_r    <= S_START;
                        rlen_r  <= {(PAYLOAD_AW+1){1'b1}};
                    end
                end
                S_START:
                    if (f_ready)
                        st_r <= S_CODE;
                S_CODE:
                    if (f_ready)
                    begin
                        resc_r <= need_esc;
                        if (!need_esc)
                            st_r <= (&rlen_r) ? S_LOG : ((rlen_r == ridx_r) ? S_STOP : S_BODY);
                    end
                S_BODY:
                    if (f_ready)
                    begin
                        resc_r <= need_esc;
                        if (!need_esc)
                        begin
                            ridx_r <= ridx_r + 1'b1;
                            if (ridx_r + 1'b1 == rlen_r)
                                st_r <= S_STOP;
                        end
                    end
                S_LOG:
                    if (f_ready && log_last_r && !log_ready_r)
                    begin
                        log_last_r <= 1'b0;
                        st_r       <= S_IDLE;
                        busy_r     <= 1'b0;
                    end
                    else if (f_ready && log_valid && !log_ready_r)
                    begin
                        resc_r <= need_esc;
                        if (!need_esc)
                        begin
                            log_ready_r <= 1'b1;
                            log_last_r  <= log_last;
                        end
                    end
                S_STOP:
                    if (f_ready)
                    begin
                        st_r   <= S_IDLE;
                        busy_r <= 1'b0;
                    end
                default:
                    st_r <= S_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Transmit FIFO and output stage
    // ****************************************************************
    frame_fifo #(
        .WIDTH (9),
        .DEPTH (`FIFO_DEPTH),
        .AW    (4)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n_r),
        .in_data   (f_in),
        .in_valid  (f_valid && !(st_r == S_LOG && log_ready_r)),
        .in_ready  (f_ready),
        .out_data  (f_out),
        .out_valid (f_out_valid),
        .out_ready (!tx_valid_r && !txr_r)
    );

    always @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            tx_byte_r  <= 8'h00;
            tx_valid_r <= 1'b0;
        end
        else if (tx_valid_r)
        begin
            if (txr_r)
                tx_valid_r <= 1'b0;
        end
        // Next byte waits until the synced ready has drained
        else if (f_out_valid && !txr_r)
        begin
            tx_byte_r  <= f_out[7:0];
            tx_valid_r <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== sim/link_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "cmd_link_regs.vh"
// ****
// Port checker
// ****
module link_chk #(
    parameter [7:0] SW_VERSION = 8'h01,
    parameter       PAYLOAD_AW = 4
) (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic [7:0] rx_byte,
    input wire logic       rx_valid,
    input wire logic [7:0] tx_byte_r,
    input wire logic       tx_valid_r,
    input wire logic       tx_ready,
    input wire logic [7:0] log_byte,
    input wire logic       log_valid,
    input wire logic       log_ready_r,
    input wire logic       log_last,
    input wire logic       sw_reset_r,
    input wire logic       busy_r
);
    logic after_stop;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // Last handed byte closed a frame
    always @(posedge clk or negedge resetn)
        if (!resetn)
            after_stop <= 1'b1;
        else if ($fell(tx_valid_r))
            after_stop <= (tx_byte_r == `FRM_STOP);
    sequence s_no_ready;
        (!tx_ready)[*4] ##0 tx_valid_r;
    endsequence
    sequence s_ready_seen;
        $past(tx_ready) || $past(tx_ready, 2) || $past(tx_ready, 3) || $past(tx_ready, 4);
    endsequence
    a_rst_pulse_one: assert property (sw_reset_r |=> !sw_reset_r)
        else $error("reset pulse too long");
    a_log_pulse_one: assert property (log_ready_r |=> !log_ready_r)
        else $error("log ready pulse too long");
    a_log_take_valid: assert property (log_ready_r |-> $past(log_valid))
        else $error("log byte taken without valid");
    a_valid_holds: assert property (s_no_ready |=> tx_valid_r)
        else $error("tx valid dropped without ready");
    a_byte_holds: assert property (s_no_ready |=> $stable(tx_byte_r))
        else $error("tx byte changed while waiting");
    a_drop_after_ready: assert property ($fell(tx_valid_r) |-> s_ready_seen)
        else $error("tx valid fell with no ready");
    a_quiet_after_reset: assert property ($rose(resetn) |-> (!tx_valid_r && !sw_reset_r && !busy_r)[*2])
        else $error("outputs active right after reset");
    a_frame_opens: assert property ($rose(tx_valid_r) && after_stop |-> tx_byte_r == `FRM_START)
        else $error("frame not opened by start marker");
endmodule
bind serial_command_link link_chk #(.SW_VERSION(SW_VERSION), .PAYLOAD_AW(PAYLOAD_AW)) u_chk (
    .clk(clk), .resetn(resetn), .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_byte_r(tx_byte_r),
    .tx_valid_r(tx_valid_r), .tx_ready(tx_ready), .log_byte(log_byte), .log_valid(log_valid),
    .log_ready_r(log_ready_r), .log_last(log_last), .sw_reset_r(sw_reset_r), .busy_r(busy_r)
);
`default_nettype wire

// ===== sim/uart_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Host end of the link
// ****
module uart_host_model (
    input  wire logic       clk,
    output logic      [7:0] rx_byte,
    output logic            rx_valid,
    input  wire logic [7:0] tx_byte_r,
    input  wire logic       tx_valid_r,
    output logic            tx_ready
);
    logic [7:0] got[$];
    int         stall = 0;
    initial
    begin
        rx_byte = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
    end
    // Strobe held four cycles; released line shows the inverse
    task automatic send_byte(input logic [7:0] b);
        @(negedge clk);
        rx_byte = b;
        rx_valid = 1'b1;
        repeat (4) @(negedge clk);
        rx_valid = 1'b0;
        rx_byte = ~b;
        repeat (4) @(negedge clk);
    endtask
    // Always listening, optionally slow to accept
    always
    begin
        @(negedge clk);
        if (tx_valid_r === 1'b1)
        begin
            got.push_back(tx_byte_r);
            repeat (stall + 1) @(negedge clk);
            tx_ready = 1'b1;
            for (int i = 0; i < 30 && tx_valid_r === 1'b1; i++) @(negedge clk);
            tx_ready = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== sim/tb_serial_command_link.sv
`timescale 1ns/100ps
`default_nettype none
`include "cmd_link_regs.vh"
module tb_serial_command_link;
    localparam logic [7:0] SW_VER = 8'h7d;
    logic       clk;
    logic       resetn;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic [7:0] tx_byte_r;
    logic       tx_valid_r;
    logic       tx_ready;
    logic [7:0] log_byte;
    logic       log_valid;
    logic       log_ready_r;
    logic       log_last;
    logic       sw_reset_r;
    logic       busy_r;
    int         error_cnt = 0;
    int         n_tests = 0;
    int         pulses = 0;
    logic [7:0] fr[$];
    logic [7:0] pl[$];
    // ****
    // Device and host
    // ****
    serial_command_link #(.SW_VERSION(SW_VER)) DUT (
        .clk(clk), .resetn(resetn), .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_byte_r(tx_byte_r),
        .tx_valid_r(tx_valid_r), .tx_ready(tx_ready), .log_byte(log_byte), .log_valid(log_valid),
        .log_ready_r(log_ready_r), .log_last(log_last), .sw_reset_r(sw_reset_r), .busy_r(busy_r));
    uart_host_model host (.clk(clk), .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_byte_r(tx_byte_r),
        .tx_valid_r(tx_valid_r), .tx_ready(tx_ready));
    always @(negedge clk)
        if (sw_reset_r === 1'b1)
            pulses++;
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic put(input logic [7:0] b);
        if (b == `FRM_START || b == `FRM_STOP || b == `FRM_ESC)
        begin
            fr.push_back(`FRM_ESC);
            fr.push_back(~b);
        end
        else
            fr.push_back(b);
    endtask
    task automatic mk(input logic [7:0] code);
        fr = {`FRM_START};
        put(code);
        foreach (pl[i]) put(pl[i]);
        fr.push_back(`FRM_STOP);
    endtask
    task automatic send();
        foreach (fr[i]) host.send_byte(fr[i]);
    endtask
    // Wait for the whole reply before the next command
    task automatic await(input string what);
        int k;
        k = 0;
        while (host.got.size() < fr.size() && k < 4000)
        begin
            @(negedge clk);
            k++;
        end
        repeat (40) @(negedge clk);
        if (k == 4000)
        begin
            error_cnt++;
            $display("FAIL %s expected reply seen none", what);
            stop_test();
        end
        chk({what, " len"}, 8'(fr.size()), 8'(host.got.size()));
        foreach (fr[i])
            if (i < host.got.size())
                chk(what, fr[i], host.got[i]);
        chk({what, " busy"}, 8'h00, {7'h00, busy_r});
        host.got = {};
        $display("test %s ends", what);
    endtask
    task automatic log_send(input logic [7:0] b, input logic last);
        int k;
        log_byte = b;
        log_valid = 1'b1;
        log_last = last;
        k = 0;
        do
        begin
            @(negedge clk);
            k++;
        end
        while (log_ready_r !== 1'b1 && k < 200);
        if (k == 200)
        begin
            error_cnt++;
            $display("FAIL log ready expected 1 seen 0");
            stop_test();
        end
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_version();
        pl = {};
        mk(`CMD_SW_VERSION);
        send();
        pl = {SW_VER};
        mk(`CMD_SW_VERSION);
        await("version");
    endtask
    task automatic t_echo();
        pl = {`FRM_START, `FRM_STOP, `FRM_ESC, 8'h00, 8'hff};
        while (pl.size() < `MAX_PAYLOAD) pl.push_back(8'(pl.size()));
        host.stall = 6;
        mk(`CMD_TEST);
        send();
        await("echo");
        host.stall = 0;
    endtask
    task automatic t_ack();
        pulses = 0;
        pl = {};
        mk(`CMD_SW_RESET);
        send();
        mk(`CMD_ACK);
        await("reset ack");
        chk("reset pulses", 8'h01, 8'(pulses));
    endtask
    task automatic t_nak();
        logic [7:0] codes[3] = '{8'h10, `FRM_START, `CMD_INVALID};
        foreach (codes[i])
        begin
            pl = {};
            mk(codes[i]);
            send();
            mk(`CMD_NAK);
            await("nak code");
        end
        pl = {};
        repeat (`MAX_PAYLOAD + 1) pl.push_back(8'h5a);
        mk(`CMD_TEST);
        send();
        pl = {};
        mk(`CMD_NAK);
        await("nak long");
    endtask
    task automatic t_junk();
        host.send_byte(8'h55);
        host.send_byte(`FRM_STOP);
        host.send_byte(`FRM_START);
        host.send_byte(`FRM_STOP);
        t_version();
    endtask
    task automatic t_log();
        log_send(8'h11, 1'b0);
        log_send(`FRM_START, 1'b0);
        log_send(8'h33, 1'b1);
        log_valid = 1'b0;
        log_last = 1'b0;
        pl = {8'h11, `FRM_START, 8'h33};
        mk(`CMD_LOG);
        await("log");
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        resetn = 1'b0;
        log_byte = 8'h00;
        log_valid = 1'b0;
        log_last = 1'b0;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        repeat (6) @(negedge clk);
        t_version();
        t_echo();
        t_ack();
        t_nak();
        t_junk();
        t_log();
        stop_test();
    end
endmodule
`default_nettype wire
